// File: core/spu_pkg.sv
// Package with the constants and types of the spreader parameter memory update block.
// Summary of operation
// - A DPCH spreader gets slot mask, DTX, compressed mode type and next block pointer copied from each header.
// - An HS-PDSCH spreader gets message handler set id, code, modulation, DTX, diversity mode and next pointer each sub-frame.
// - An S-CCPCH spreader writes its gain every frame and that write never collides away.
// - A fetching spreader fetches one header per access slot, frame or sub-frame while its data path is active.
// - A header fetch write loses its copied words when software writes any spreader's memory in the same cycle.
// - After a dropped write for period N the data path uses the period N-1 values of the copied words.
// - High-speed packet spreaders fetch once per sub-frame, so collisions hit them more often.
// - Sync and pilot spreaders never fetch; every other channel type does.
package spu_pkg;

    localparam int SPU_ADDR_W = 8;
    localparam int SPU_DATA_W = 32;

    // Spreader memory word map: index within a spreader's area.
    localparam logic [3:0] SPU_W_CHTYPE   = 4'h0;
    localparam logic [3:0] SPU_W_SLOTMASK = 4'h1;
    localparam logic [3:0] SPU_W_DTX      = 4'h2;
    localparam logic [3:0] SPU_W_CMTYPE   = 4'h3;
    localparam logic [3:0] SPU_W_NEXTPTR  = 4'h4;
    localparam logic [3:0] SPU_W_GAIN     = 4'h5;
    localparam logic [3:0] SPU_W_MHSET    = 4'h6;
    localparam logic [3:0] SPU_W_CODE     = 4'h7;
    localparam logic [3:0] SPU_W_MOD      = 4'h8;
    localparam logic [3:0] SPU_W_DIV      = 4'h9;
    localparam int         SPU_WORDS      = 16;

    // Header field presence bits, one per memory word index.
    localparam int SPU_F_W = 16;

    typedef enum logic [3:0] {
        SPU_CH_PSCH   = 4'h0,
        SPU_CH_SSCH   = 4'h1,
        SPU_CH_PCPICH = 4'h2,
        SPU_CH_SCPICH = 4'h3,
        SPU_CH_DPCH   = 4'h4,
        SPU_CH_MICH   = 4'h5,
        SPU_CH_PICH   = 4'h6,
        SPU_CH_PCCPCH = 4'h7,
        SPU_CH_SCCPCH = 4'h8,
        SPU_CH_FDPCH  = 4'h9,
        SPU_CH_AICH   = 4'hA,
        SPU_CH_EAICH  = 4'hB,
        SPU_CH_HSPDSCH= 4'hC,
        SPU_CH_HSSCCH = 4'hD,
        SPU_CH_EHICH  = 4'hE,
        SPU_CH_EAGCH  = 4'hF
    } spu_chtype_e;

    typedef enum logic [1:0] {
        SPU_PER_NONE = 2'h0,
        SPU_PER_SLOT = 2'h1,
        SPU_PER_FRAME= 2'h2,
        SPU_PER_SUB  = 2'h3
    } spu_period_e;

    localparam logic [SPU_DATA_W-1:0] SPU_RST_WORD = 32'h0000_0000;

endpackage

// File: core/spu_field_map.sv
// Decoder from channel type to fetched header fields and fetch period.
`timescale 1ns/100ps
`default_nettype none
module spu_field_map
(
    input  wire logic [3:0]  chtype_i,   // Channel type of the spreader.
    output logic             fetching_o, // Spreader fetches headers.
    output logic [1:0]       period_o,   // Fetch period kind.
    output logic [15:0]      copy_o,     // Words copied with collision loss.
    output logic [15:0]      safe_o      // Words copied without loss.
);
    logic [15:0] f;

    always_comb
    begin
        f = 16'h0000;
        f[spu_pkg::SPU_W_DTX] = 1'b1;
        safe_o = 16'h0000;
        fetching_o = 1'b1;
        period_o = spu_pkg::SPU_PER_FRAME;
        unique case (spu_pkg::spu_chtype_e'(chtype_i))
            spu_pkg::SPU_CH_PSCH, spu_pkg::SPU_CH_SSCH,
            spu_pkg::SPU_CH_PCPICH, spu_pkg::SPU_CH_SCPICH:
            begin
                f = 16'h0000;
                fetching_o = 1'b0;
                period_o = spu_pkg::SPU_PER_NONE;
            end
            spu_pkg::SPU_CH_DPCH:
            begin
                f[spu_pkg::SPU_W_SLOTMASK] = 1'b1;
                f[spu_pkg::SPU_W_CMTYPE] = 1'b1;
                f[spu_pkg::SPU_W_NEXTPTR] = 1'b1;
            end
            spu_pkg::SPU_CH_MICH, spu_pkg::SPU_CH_PICH,
            spu_pkg::SPU_CH_PCCPCH:
                f[spu_pkg::SPU_W_GAIN] = 1'b1;
            spu_pkg::SPU_CH_SCCPCH:
            begin
                f[spu_pkg::SPU_W_NEXTPTR] = 1'b1;
                safe_o[spu_pkg::SPU_W_GAIN] = 1'b1;
            end
            spu_pkg::SPU_CH_FDPCH:
                f[spu_pkg::SPU_W_SLOTMASK] = 1'b1;
            spu_pkg::SPU_CH_AICH, spu_pkg::SPU_CH_EAICH:
                period_o = spu_pkg::SPU_PER_SLOT;
            spu_pkg::SPU_CH_HSPDSCH:
            begin
                f[spu_pkg::SPU_W_MHSET] = 1'b1;
                f[spu_pkg::SPU_W_CODE] = 1'b1;
                f[spu_pkg::SPU_W_MOD] = 1'b1;
                f[spu_pkg::SPU_W_DIV] = 1'b1;
                f[spu_pkg::SPU_W_NEXTPTR] = 1'b1;
                period_o = spu_pkg::SPU_PER_SUB;
            end
            spu_pkg::SPU_CH_HSSCCH:
            begin
                f[spu_pkg::SPU_W_DIV] = 1'b1;
                period_o = spu_pkg::SPU_PER_SUB;
            end
            spu_pkg::SPU_CH_EHICH, spu_pkg::SPU_CH_EAGCH:
                period_o = spu_pkg::SPU_PER_SUB;
        endcase
        copy_o = f;
    end
endmodule
`default_nettype wire

// File: core/spu_param_mem.sv
// Spreader parameter memory with software and header fetch write ports.
`timescale 1ns/100ps
`default_nettype none
module spu_param_mem
#(
    parameter int NUM_SPR = 16                 // Number of spreaders.
)
(
    input  wire logic                  CLK_SYS_I,     // 125 MHz clock.
    input  wire logic                  RST_N_I,       // Sync reset, low.
    input  wire logic [7:0]            SW_ADDR_I,     // Spreader and word.
    input  wire logic [31:0]           SW_WDATA_I,    // Software data.
    input  wire logic                  SW_WR_I,       // Software write.
    input  wire logic                  SW_RD_I,       // Software read.
    output logic      [31:0]           SW_RDATA_O,    // Read data.
    input  wire logic [$clog2(NUM_SPR)-1:0] FETCH_SPR_I, // Fetch target.
    input  wire logic                  FETCH_WR_I,    // Header write pulse.
    input  wire logic [15:0]           FETCH_SLOTMASK_I, // Header slot mask.
    input  wire logic                  FETCH_DTX_I,   // Header DTX flag.
    input  wire logic [3:0]            FETCH_CMTYPE_I, // Compressed mode.
    input  wire logic [15:0]           FETCH_NEXTPTR_I, // Next block pointer.
    input  wire logic [15:0]           FETCH_GAIN_I,  // Channel gain.
    input  wire logic [7:0]            FETCH_MHSET_I, // Handler set id.
    input  wire logic [7:0]            FETCH_CODE_I,  // Channelization code.
    input  wire logic [1:0]            FETCH_MOD_I,   // Modulation.
    input  wire logic [1:0]            FETCH_DIV_I,   // Diversity mode.
    input  wire logic [NUM_SPR-1:0]    ACTIVE_I,      // Data path active.
    output logic      [NUM_SPR-1:0]    FETCH_EN_O,    // Spreader may fetch.
    output logic      [NUM_SPR*2-1:0]  PERIOD_O,      // Fetch period kind.
    output logic                       FETCH_LOST_O,  // Fetch write dropped.
    output logic      [NUM_SPR*32-1:0] DP_DTX_O       // Words used by path.
);
    localparam int SW = $clog2(NUM_SPR);

    logic [31:0]  mem [NUM_SPR][spu_pkg::SPU_WORDS];
    logic [31:0]  hdr [spu_pkg::SPU_WORDS];
    logic [15:0]  copy;
    logic [15:0]  safe;
    logic [15:0]  tmap_copy [NUM_SPR];
    logic [15:0]  tmap_safe [NUM_SPR];
    logic         collide;
    logic [SW-1:0] sw_spr;
    logic [3:0]   sw_word;

    assign sw_spr  = SW_ADDR_I[4+SW-1:4];
    assign sw_word = SW_ADDR_I[3:0];

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NUM_SPR; g++)
        begin : g_spr
            logic fetching;
            logic [1:0] per;
            spu_field_map u_map
            (
                .chtype_i   (mem[g][spu_pkg::SPU_W_CHTYPE][3:0]),
                .fetching_o (fetching),
                .period_o   (per),
                .copy_o     (tmap_copy[g]),
                .safe_o     (tmap_safe[g])
            );
            assign FETCH_EN_O[g] = fetching & ACTIVE_I[g];
            assign PERIOD_O[g*2 +: 2] = per;
            assign DP_DTX_O[g*32 +: 32] = mem[g][spu_pkg::SPU_W_DTX];
        end
    endgenerate

    assign copy = tmap_copy[FETCH_SPR_I];
    assign safe = tmap_safe[FETCH_SPR_I];

    always_comb
    begin
        for (int i = 0; i < spu_pkg::SPU_WORDS; i++)
            hdr[i] = spu_pkg::SPU_RST_WORD;
        hdr[spu_pkg::SPU_W_SLOTMASK] = {16'h0000, FETCH_SLOTMASK_I};
        hdr[spu_pkg::SPU_W_DTX]      = {31'h0000_0000, FETCH_DTX_I};
        hdr[spu_pkg::SPU_W_CMTYPE]   = {28'h000_0000, FETCH_CMTYPE_I};
        hdr[spu_pkg::SPU_W_NEXTPTR]  = {16'h0000, FETCH_NEXTPTR_I};
        hdr[spu_pkg::SPU_W_GAIN]     = {16'h0000, FETCH_GAIN_I};
        hdr[spu_pkg::SPU_W_MHSET]    = {24'h00_0000, FETCH_MHSET_I};
        hdr[spu_pkg::SPU_W_CODE]     = {24'h00_0000, FETCH_CODE_I};
        hdr[spu_pkg::SPU_W_MOD]      = {30'h0000_0000, FETCH_MOD_I};
        hdr[spu_pkg::SPU_W_DIV]      = {30'h0000_0000, FETCH_DIV_I};
    end

    // Any software write kills the copied (non-safe) words of the fetch write of the same
    // cycle, whichever spreader it targets; those words then keep older header values.
    assign collide = FETCH_WR_I & SW_WR_I;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            for (int s = 0; s < NUM_SPR; s++)
                for (int w = 0; w < spu_pkg::SPU_WORDS; w++)
                    mem[s][w] <= spu_pkg::SPU_RST_WORD;
        end
        else
        begin
            if (FETCH_WR_I && FETCH_EN_O[FETCH_SPR_I])
                for (int w = 0; w < spu_pkg::SPU_WORDS; w++)
                    if ((copy[w] && !collide) || safe[w])
                        mem[FETCH_SPR_I][w] <= hdr[w];
            if (SW_WR_I)
                mem[sw_spr][sw_word] <= SW_WDATA_I;
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            FETCH_LOST_O <= 1'b0;
        else
            FETCH_LOST_O <= collide && FETCH_EN_O[FETCH_SPR_I]
                            && (copy != 16'h0000);
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            SW_RDATA_O <= spu_pkg::SPU_RST_WORD;
        else if (SW_RD_I)
            SW_RDATA_O <= mem[sw_spr][sw_word];
        else
            SW_RDATA_O <= spu_pkg::SPU_RST_WORD;
    end
endmodule
`default_nettype wire

// File: test/spu_param_mem_asserts.sv
// Concurrent checks on the ports of the spreader parameter memory.
`timescale 1ns/100ps
`default_nettype none
module spu_param_mem_asserts
#(
    parameter int NUM_SPR = 16                      // Spreaders.
)
(
    input  wire logic                  CLK_SYS_I,    // Clock.
    input  wire logic                  RST_N_I,      // Reset, low.
    input  wire logic [7:0]            SW_ADDR_I,    // Address.
    input  wire logic [31:0]           SW_WDATA_I,   // Write data.
    input  wire logic                  SW_WR_I,      // Write.
    input  wire logic                  SW_RD_I,      // Read.
    input  wire logic [31:0]           SW_RDATA_O,   // Read data.
    input  wire logic [$clog2(NUM_SPR)-1:0] FETCH_SPR_I, // Target.
    input  wire logic                  FETCH_WR_I,   // Fetch write.
    input  wire logic                  FETCH_DTX_I,  // DTX flag.
    input  wire logic [NUM_SPR-1:0]    ACTIVE_I,     // Active.
    input  wire logic [NUM_SPR-1:0]    FETCH_EN_O,   // Fetch enable.
    input  wire logic [NUM_SPR*2-1:0]  PERIOD_O,     // Periods.
    input  wire logic                  FETCH_LOST_O, // Lost flag.
    input  wire logic [NUM_SPR*32-1:0] DP_DTX_O      // DTX words.
);
    logic [$clog2(NUM_SPR)-1:0] spr_q;
    wire logic hit = FETCH_WR_I && FETCH_EN_O[FETCH_SPR_I];
    // DTX bit of the spreader targeted now and of the one targeted a cycle
    // ago; indexing through a sampled function would mix up the two cycles.
    wire logic cur_dtx = DP_DTX_O[32*FETCH_SPR_I];
    wire logic tgt_dtx = DP_DTX_O[32*spr_q];
    always_ff @(posedge CLK_SYS_I)
        spr_q <= FETCH_SPR_I;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////////////////////////////////////
    a_loss_flagged: assert property (hit && SW_WR_I |=> FETCH_LOST_O)
        else $error("Collision not flagged.");
    a_loss_cause: assert property (
        FETCH_LOST_O |-> $past(FETCH_WR_I) && $past(SW_WR_I))
        else $error("Loss flagged without collision.");
    a_dtx_fetched: assert property (hit && !SW_WR_I |=>
        tgt_dtx == $past(FETCH_DTX_I))
        else $error("Fetched DTX not stored.");
    a_dtx_kept: assert property (
        FETCH_WR_I && SW_WR_I && SW_ADDR_I[3:0] != 4'h2 |=>
        tgt_dtx == $past(cur_dtx))
        else $error("Lost fetch changed DTX.");
    a_idle_kept: assert property (
        FETCH_WR_I && !FETCH_EN_O[FETCH_SPR_I] && !SW_WR_I |=>
        tgt_dtx == $past(cur_dtx))
        else $error("Idle spreader took a fetch.");
    a_fetch_active: assert property ((FETCH_EN_O & ~ACTIVE_I) == '0)
        else $error("Inactive spreader fetching.");
    a_period_set: assert property (
        FETCH_EN_O[FETCH_SPR_I] |-> PERIOD_O[2*FETCH_SPR_I+:2] != 2'h0)
        else $error("Fetching spreader without period.");
    a_write_read: assert property (
        SW_WR_I ##2 (SW_RD_I && SW_ADDR_I == $past(SW_ADDR_I, 2)) |=>
        SW_RDATA_O == $past(SW_WDATA_I, 3))
        else $error("Read back differs from write.");
    c_collision: cover property (hit && SW_WR_I);
    c_fetch: cover property (hit && !SW_WR_I);
    c_read: cover property (SW_RD_I);
endmodule
`default_nettype wire

// File: test/spu_fetch_model.sv
// Header fetch engine model that writes one header per period.
`timescale 1ns/100ps
`default_nettype none
module spu_fetch_model
(
    input  wire logic        clk_i,   // Accelerator clock.
    input  wire logic        rst_n_i, // Sync reset, low.
    input  wire logic        go_i,    // Fetch one header now.
    input  wire logic        hold_i,  // Keep this header's values for the next fetch.
    output logic             wr_o,    // Header write strobe.
    output logic [72:0]      hdr_o    // Packed header fields.
);
    logic [7:0]  v;
    logic [72:0] hdr;
    // Each period has its own header while hold_i is low, so fields change on every such fetch.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            v <= 8'h81;
        else if (go_i && !hold_i)
            v <= v + 8'h01;
    end
    assign hdr = {8'h10, v, v[0], v[3:0], 8'h40, v, 8'h50, v, v, v,
                  v[1:0], v[1:0]};
    // Outside a fetch the lines show the inverse, so stale sampling shows.
    assign hdr_o = go_i ? hdr : ~hdr;
    assign wr_o = go_i;
endmodule
`default_nettype wire

// File: test/spu_param_mem_tb.sv
// Self-checking testbench of the spreader parameter memory.
`timescale 1ns/100ps
`default_nettype none
module spu_param_mem_tb;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic        fwr, lost, lst;
    logic        hold = 1'b0;
    logic [7:0]  addr = 8'h00, v = 8'h81;
    logic [3:0]  spr = 4'h0;
    logic [15:0] act = 16'hFFFF, fen;
    logic [31:0] wdata = 32'h0, rdata, rdv, old, per;
    logic [72:0] hdr;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    localparam logic [15:0] MASK [16] = '{16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h001E, 16'h0024, 16'h0024, 16'h0024, 16'h0034,
        16'h0006, 16'h0004, 16'h0004, 16'h03D4, 16'h0204, 16'h0004, 16'h0004};
    spu_fetch_model u_spu_fetch_model (.clk_i(clk), .rst_n_i(rst_n),
        .go_i(go), .hold_i(hold), .wr_o(fwr), .hdr_o(hdr));
    spu_param_mem u_spu_param_mem (.CLK_SYS_I(clk), .RST_N_I(rst_n),
        .SW_ADDR_I(addr), .SW_WDATA_I(wdata), .SW_WR_I(wr), .SW_RD_I(rd),
        .SW_RDATA_O(rdata), .FETCH_SPR_I(spr), .FETCH_WR_I(fwr),
        .FETCH_SLOTMASK_I(hdr[72:57]), .FETCH_DTX_I(hdr[56]),
        .FETCH_CMTYPE_I(hdr[55:52]), .FETCH_NEXTPTR_I(hdr[51:36]),
        .FETCH_GAIN_I(hdr[35:20]), .FETCH_MHSET_I(hdr[19:12]),
        .FETCH_CODE_I(hdr[11:4]), .FETCH_MOD_I(hdr[3:2]),
        .FETCH_DIV_I(hdr[1:0]), .ACTIVE_I(act), .FETCH_EN_O(fen),
        .PERIOD_O(per), .FETCH_LOST_O(lost), .DP_DTX_O());
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] fv(input int w, input logic [7:0] x);
        case (w)
            1, 4, 5: return {16'h0000, w[3:0], 4'h0, x};
            2:       return {31'h0, x[0]};
            3:       return {28'h0, x[3:0]};
            6, 7:    return {24'h0, x};
            default: return {30'h0, x[1:0]};
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One bus cycle; a gap cycle follows so no strobe is driven twice.
    task automatic bus(input logic w, r, g, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        wr <= w;
        rd <= r;
        go <= g;
        addr <= a;
        wdata <= d;
        spr <= s;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        go <= 1'b0;
        #1;
        rdv = rdata;
        lst = lost;
        if (g && !hold)
            v++;
    endtask
    task automatic t_types();
        for (int t = 0; t < 16; t++)
        begin
            bus(1, 0, 0, {t[3:0], 4'h0}, t, 4'h0);
            bus(0, 1, 0, {t[3:0], 4'h0}, 0, 4'h0);
            chk(rdv, t);
            bus(0, 0, 1, 8'h00, 0, t[3:0]);
            chk(lst, 1'b0);
            for (int w = 1; w < 10; w++)
            begin
                bus(0, 1, 0, {t[3:0], w[3:0]}, 0, 4'h0);
                chk(rdv, MASK[t][w] ? fv(w, v - 8'h01) : 32'h0);
            end
        end
        chk(fen, 16'hFFF0);
        chk(per, 32'hFF5AAA00);
    endtask
    task automatic t_loss();
        for (int s = 8; s < 13; s += 4)
        begin
            bus(0, 0, 1, 8'h00, 0, s[3:0]);
            bus(1, 0, 1, 8'h1F, 32'h5, s[3:0]);
            chk(lst, 1'b1);
            bus(0, 1, 0, {s[3:0], 4'h2}, 0, 4'h0);
            chk(rdv, fv(2, v - 8'h02));
            bus(0, 1, 0, {s[3:0], 4'h5}, 0, 4'h0);
            chk(rdv, s == 8 ? fv(5, v - 8'h01) : 32'h0);
        end
    endtask
    task automatic t_idle();
        @(posedge clk);
        act <= 16'hFEFF;
        bus(0, 1, 0, 8'h84, 0, 4'h0);
        old = rdv;
        bus(0, 0, 1, 8'h00, 0, 4'h8);
        bus(0, 0, 1, 8'h00, 0, 4'h8);
        bus(0, 1, 0, 8'h84, 0, 4'h0);
        chk(rdv, old);
        chk(fen[8], 1'b0);
    endtask
    // The header of the lost period repeats the one before it, so the
    // dropped write must leave no trace in what the data path reads.
    task automatic t_repeat();
        hold <= 1'b1;
        bus(0, 0, 1, 8'h00, 0, 4'hC);
        bus(1, 0, 1, 8'h3F, 32'h7, 4'hC);
        chk(lst, 1'b1);
        bus(0, 1, 0, 8'hC7, 0, 4'h0);
        chk(rdv, fv(7, v));
        hold <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_types();
        t_loss();
        t_repeat();
        t_idle();
        print_verdict();
    end
endmodule
bind spu_param_mem spu_param_mem_asserts #(.NUM_SPR(NUM_SPR))
    u_spu_param_mem_asserts (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
    .SW_ADDR_I(SW_ADDR_I), .SW_WDATA_I(SW_WDATA_I), .SW_WR_I(SW_WR_I),
    .SW_RD_I(SW_RD_I), .SW_RDATA_O(SW_RDATA_O), .FETCH_SPR_I(FETCH_SPR_I),
    .FETCH_WR_I(FETCH_WR_I), .FETCH_DTX_I(FETCH_DTX_I), .ACTIVE_I(ACTIVE_I),
    .FETCH_EN_O(FETCH_EN_O), .PERIOD_O(PERIOD_O),
    .FETCH_LOST_O(FETCH_LOST_O), .DP_DTX_O(DP_DTX_O));
`default_nettype wire
